// File: hdl/dispatch_map.svh
`ifndef DISPATCH_MAP_SVH
`define DISPATCH_MAP_SVH
// Overview of operation
// R01 - process lines ranked A highest, then B, then C, D lowest
// R02 - timed level and system errors outrank and are never preempted by lines
// R03 - lower program levels may be preempted after any single operation
// R04 - no handler installed: request dropped, interrupted program simply continues (an i/o error without handler enters stop here)
// R05 - one further request edge per line is held while its handler runs
// R06 - after a handler, highest pending line first, including the same line
// R07 - higher line preempts a lower handler at once; lower resumes afterwards
// R08 - global disable stops line dispatch but one request per line still held
// R09 - each level has its own mask, acting when global disable is off
// R10 - no line dispatch during restart unless enabled at handler start
// R11 - request to handler start takes 23 to 85 us, services excluded
// R12 - operating system service calls cannot be interrupted; requests wait
// R13 - one-shot expiry raises timed request unless disabled or masked
// R14 - reactivation restarts countdown with new value; value 0 stops it
// R15 - running duration shown in system word 101; cleared to 0 at expiry
// R16 - one-shot counts 1 ms steps, 1 to 65535 ms, may end 1 ms early
// R17 - timed handler preempts lower levels, only system errors preempt it
// R18 - timed level suppressed by its own mask and by global disable
// R19 - one timed request held while blocked; another raises a collision
// R20 - system errors highest, masked individually only, never by global disable
// R21 - several system errors are all recorded and served one after another
// R22 - scan overrun: handler if installed else stop; second overrun forces stop
// R23 - each process line dispatches its own dedicated handler
// R24 - no new collision recorded while one with that code is unprocessed
// R25 - priority encoder over pending unmasked requests, checked at operation boundaries

// ==============================
// source indices, low to high priority
`define NUM_LINES      4
`define NUM_SRC        8
`define SRC_LINE_D     0
`define SRC_LINE_C     1
`define SRC_LINE_B     2
`define SRC_LINE_A     3
`define SRC_ONESHOT    4
`define SRC_COLLISION  5
`define SRC_IO_ERROR   6
`define SRC_OVERRUN    7

// ==============================
// priorities; program level sits at zero, a source runs at index plus one
`define PRIO_PROGRAM   4'h0
`define PRIO_SYS_FIRST 4'h6
`define STACK_DEPTH    9

// ==============================
// timing
`define CLK_MHZ        100
`define LAT_MIN_US     23
`define LAT_MAX_US     85
`define LAT_MIN_CYC    (`LAT_MIN_US * `CLK_MHZ)
`define LAT_MAX_CYC    (`LAT_MAX_US * `CLK_MHZ)
`define TICK_MS        1
`define TICK_CYC       (`TICK_MS * 1000 * `CLK_MHZ)

// ==============================
// values
`define ONESHOT_OFF        16'h0000
`define COLL_CODE_NONE     4'h0
`define COLL_CODE_ONESHOT  4'h1
`endif

// File: hdl/dispatch_pkg.sv
package dispatch_pkg;
	typedef logic [3:0]  prio_t;
	typedef logic [15:0] ms_count_t;
	typedef enum {RUN, STOPPED} run_state_e;
endpackage : dispatch_pkg

// File: hdl/req_latch.sv
`timescale 1ns/1ps
// one pending request per source, taken on a rising edge
module req_latch (
	input  wire logic clock,    // system clock
	input  wire logic rst,      // async reset, high
	input  wire logic req_in,   // request level or pulse
	input  wire logic clr,      // served, drop pending
	output logic      pend,     // request held
	output logic      overflow  // edge seen while already held
);
	logic prev_reg;
	logic edge_seen;

	assign edge_seen = req_in & ~prev_reg;
	assign overflow  = edge_seen & pend;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= req_in;
		end
	end

	// set beats clear so a fresh edge in the serving cycle survives
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pend <= 1'b0;
		end else if (edge_seen) begin
			pend <= 1'b1; // R05
		end else if (clr) begin
			pend <= 1'b0;
		end
	end
endmodule : req_latch

// File: hdl/oneshot_timer.sv
`timescale 1ns/1ps
`include "dispatch_map.svh"
module oneshot_timer
	import dispatch_pkg::*;
#(
	parameter int TICK_CYC = `TICK_CYC
) (
	input  wire logic      clock,    // system clock
	input  wire logic      rst,      // async reset, high
	input  wire ms_count_t act_value, // duration in ms
	input  wire logic      activate, // activation strobe
	output ms_count_t      sys_word, // running duration, 0 when idle
	output logic           expire    // one-cycle expiry pulse
);
	localparam int PW = $clog2(TICK_CYC + 1);
	initial begin
		if (TICK_CYC < 2) $error("tick count too small");
	end

	logic [PW-1:0] pre_reg;
	ms_count_t     cnt_reg;
	logic          tick;

	// free running prescaler: first step may be short, hence up to 1 ms early
	assign tick = (pre_reg == PW'(TICK_CYC - 1)); // R16

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= tick ? '0 : pre_reg + 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_reg  <= `ONESHOT_OFF;
			sys_word <= `ONESHOT_OFF;
			expire   <= 1'b0;
		end else begin
			expire <= 1'b0;
			if (activate) begin
				cnt_reg  <= act_value; // R14
				sys_word <= act_value; // R15
			end else if (tick && cnt_reg != `ONESHOT_OFF) begin
				cnt_reg <= cnt_reg - 1'b1;
				if (cnt_reg == 16'h0001) begin
					sys_word <= `ONESHOT_OFF; // R15
					expire   <= 1'b1;         // R13
				end
			end
		end
	end
endmodule : oneshot_timer

// File: hdl/priority_interrupt_dispatcher.sv
`timescale 1ns/1ps
`include "dispatch_map.svh"
module priority_interrupt_dispatcher
	import dispatch_pkg::*;
#(
	parameter int LAT_MIN_CYC = `LAT_MIN_CYC,
	parameter int LAT_MAX_CYC = `LAT_MAX_CYC,
	parameter int TICK_CYC    = `TICK_CYC,
	parameter int STACK_DEPTH = `STACK_DEPTH
) (
	input  wire logic       clock,                    // system clock, 100 MHz
	input  wire logic       rst,                      // async reset, high
	input  wire logic [3:0] irq_line,                 // backplane lines, bit 3 = A
	input  wire logic       io_error,                 // i/o error level
	input  wire logic       scan_overrun_signal,      // scan time ran out, pulse
	input  wire logic       scan_timer_restart,       // scan timer restarted, pulse
	input  wire logic       oneshot_activate,         // one-shot activation, pulse
	input  wire ms_count_t  oneshot_value,            // one-shot duration in ms
	input  wire logic       global_interrupt_disable, // disable strobe
	input  wire logic       global_interrupt_enable,  // enable strobe
	input  wire logic [7:0] level_mask_set,           // per-level mask, 1 = masked
	input  wire logic [7:0] handler_installed,        // handler present per level
	input  wire logic       op_boundary,              // an operation just completed
	input  wire logic       os_service_busy,          // os service call running
	input  wire logic       restart_active,           // restart handler running
	input  wire logic       handler_done,             // current handler returned
	output logic            dispatch_strobe,          // handler start, pulse
	output logic [2:0]      dispatch_source,          // source of that start
	output prio_t           active_prio,              // priority now running
	output logic [7:0]      pending,                  // held requests
	output logic            stop_mode,                // device in stop
	output ms_count_t       system_word_101,          // one-shot duration word
	output logic [3:0]      collision_code,           // unprocessed collision code
	output logic            interrupts_disabled       // global disable state
);
	localparam int LW = $clog2(LAT_MAX_CYC + 1);
	localparam int SW = $clog2(STACK_DEPTH + 1);

	initial begin
		if (STACK_DEPTH < `NUM_SRC + 1) $error("stack cannot hold every level");
		if (LAT_MIN_CYC < 1 || LAT_MAX_CYC < LAT_MIN_CYC) $error("bad latency window");
	end

	// ==============================
	// state
	run_state_e    state_reg;
	logic          gdis_reg;
	logic          restart_en_reg;
	logic          ovr_seen_reg;
	logic          ovr_req_reg;
	logic [LW-1:0] lat_cnt_reg;
	prio_t         stack_reg [STACK_DEPTH];
	logic [SW-1:0] sp_reg;

	logic [7:0]    src_in;
	logic [7:0]    pend;
	logic [7:0]    ovf;
	logic [7:0]    clr;
	logic [7:0]    eligible;
	logic          expire;
	ms_count_t     sys_word;
	prio_t         cur_prio;
	prio_t         win_prio;
	logic [2:0]    win_idx;
	logic          win_any;
	logic          can_preempt;
	logic          fire;
	logic          restart_blk;
	logic          line_ok;

	// ==============================
	// request latches, one per source
	always_comb begin
		src_in                 = 8'h00;
		src_in[3:0]            = irq_line;         // R23
		src_in[`SRC_ONESHOT]   = expire;
		src_in[`SRC_COLLISION] = ovf[`SRC_ONESHOT]; // R19
		src_in[`SRC_IO_ERROR]  = io_error;
		src_in[`SRC_OVERRUN]   = ovr_req_reg;
	end

	// collision latch ignores further events while one is held
	generate
		for (genvar i = 0; i < `NUM_SRC; i++) begin : g_src
			req_latch u_latch (
				.clock    (clock),
				.rst      (rst),
				.req_in   (src_in[i]),
				.clr      (clr[i]),
				.pend     (pend[i]),
				.overflow (ovf[i])
			); // R24 R21
		end
	endgenerate

	oneshot_timer #(
		.TICK_CYC (TICK_CYC)
	) u_oneshot (
		.clock     (clock),
		.rst       (rst),
		.act_value (oneshot_value),
		.activate  (oneshot_activate),
		.sys_word  (sys_word),
		.expire    (expire)
	);

	// ==============================
	// enables
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			gdis_reg <= 1'b0;
		end else if (global_interrupt_disable) begin
			gdis_reg <= 1'b1;
		end else if (global_interrupt_enable) begin
			gdis_reg <= 1'b0;
		end
	end

	// an enable during restart opens the lines for the rest of that restart
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			restart_en_reg <= 1'b0;
		end else if (!restart_active) begin
			restart_en_reg <= 1'b0;
		end else if (global_interrupt_enable) begin
			restart_en_reg <= 1'b1; // R10
		end
	end

	assign restart_blk = restart_active & ~restart_en_reg; // R10
	assign line_ok     = ~gdis_reg & ~restart_blk;         // R08

	// ==============================
	// eligibility and priority encoder
	always_comb begin
		eligible = pend & ~level_mask_set; // R09
		for (int i = 0; i < `NUM_LINES; i++) begin
			eligible[i] = eligible[i] & line_ok; // R08
		end
		eligible[`SRC_ONESHOT] = eligible[`SRC_ONESHOT] & ~gdis_reg; // R18 R13
		// system error levels see only their masks
	end

	always_comb begin
		win_any = 1'b0;
		win_idx = 3'h0;
		for (int i = 0; i < `NUM_SRC; i++) begin
			if (eligible[i]) begin
				win_any = 1'b1;
				win_idx = 3'(i); // R01 R25
			end
		end
	end

	assign win_prio = prio_t'({1'b0, win_idx} + 4'h1);
	assign cur_prio = (sp_reg == '0) ? `PRIO_PROGRAM : stack_reg[sp_reg - 1'b1];

	// system error levels are never preempted, not even by one another
	assign can_preempt = win_any && (win_prio > cur_prio)
		&& (cur_prio < `PRIO_SYS_FIRST); // R02 R07 R17 R20

	// ==============================
	// dispatch latency window
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lat_cnt_reg <= '0;
		end else if (!can_preempt || fire) begin
			lat_cnt_reg <= '0;
		end else if (lat_cnt_reg != LW'(LAT_MAX_CYC - 1)) begin
			lat_cnt_reg <= lat_cnt_reg + 1'b1;
		end
	end

	// a pop and a push in one cycle would race on the stack, so done wins
	assign fire = (state_reg == RUN) && can_preempt && !handler_done
		&& !os_service_busy                                      // R12
		&& (lat_cnt_reg >= LW'(LAT_MIN_CYC - 1))                   // R11
		&& (op_boundary || lat_cnt_reg == LW'(LAT_MAX_CYC - 1));   // R03 R11

	always_comb begin
		clr = 8'h00;
		if (fire) begin
			clr[win_idx] = 1'b1; // R06
		end
	end

	// ==============================
	// nesting stack of started handler levels, top one running
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sp_reg <= '0;
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_reg[i] <= `PRIO_PROGRAM;
			end
		end else if (state_reg == STOPPED) begin
			sp_reg <= '0;
		end else if (handler_done && sp_reg != '0) begin
			sp_reg <= sp_reg - 1'b1; // R07
		end else if (fire && handler_installed[win_idx]) begin
			stack_reg[sp_reg] <= win_prio;
			sp_reg            <= sp_reg + 1'b1;
		end
	end

	// ==============================
	// dispatch outputs
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dispatch_strobe <= 1'b0;
			dispatch_source <= 3'h0;
		end else begin
			dispatch_strobe <= fire && handler_installed[win_idx]; // R04
			if (fire) begin
				dispatch_source <= win_idx; // R23
			end
		end
	end

	// ==============================
	// scan overrun escalation
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ovr_seen_reg <= 1'b0;
		end else if (scan_overrun_signal) begin
			ovr_seen_reg <= 1'b1; // R22
		end else if (scan_timer_restart || restart_active) begin
			ovr_seen_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ovr_req_reg <= 1'b0;
		end else begin
			ovr_req_reg <= scan_overrun_signal && !ovr_seen_reg
				&& handler_installed[`SRC_OVERRUN]; // R22
		end
	end

	// stop holds until a restart is run
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= RUN;
		end else begin
			case (state_reg)
				RUN: begin
					if (scan_overrun_signal && (ovr_seen_reg
						|| !handler_installed[`SRC_OVERRUN])) begin
						state_reg <= STOPPED; // R22
					end else if (fire && win_idx == 3'(`SRC_IO_ERROR)
						&& !handler_installed[`SRC_IO_ERROR]) begin
						state_reg <= STOPPED;
					end
				end
				STOPPED: begin
					if (restart_active) begin
						state_reg <= RUN;
					end
				end
				default: state_reg <= RUN;
			endcase
		end
	end

	// ==============================
	// status outputs, all from flip-flops
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			active_prio         <= `PRIO_PROGRAM;
			pending             <= 8'h00;
			stop_mode           <= 1'b0;
			system_word_101     <= `ONESHOT_OFF;
			collision_code      <= `COLL_CODE_NONE;
			interrupts_disabled <= 1'b0;
		end else begin
			active_prio         <= cur_prio;
			pending             <= pend;
			stop_mode           <= (state_reg == STOPPED);
			system_word_101     <= sys_word; // R15
			collision_code      <= pend[`SRC_COLLISION] ? `COLL_CODE_ONESHOT
				: `COLL_CODE_NONE; // R24
			interrupts_disabled <= gdis_reg;
		end
	end
endmodule : priority_interrupt_dispatcher

// File: tb/irq_source_model.sv
`timescale 1ns/1ps
module irq_source_model #(
	parameter int HOLD = 4
) (
	input  wire logic       clock,    // system clock
	input  wire logic [3:0] trig,     // start one request per line
	output logic      [3:0] irq_line  // backplane lines, low when released
);
	// ==============================
	// line drivers
	// each request is a short high level; released lines fall back to idle low
	int cnt [4];
	always_ff @(posedge clock) begin
		for (int i = 0; i < 4; i++) begin
			if (trig[i]) cnt[i] <= HOLD;
			else if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
		end
	end
	always_comb begin
		for (int i = 0; i < 4; i++) irq_line[i] = (cnt[i] > 0);
	end
endmodule : irq_source_model

// File: tb/priority_interrupt_dispatcher_assertions.sv
`timescale 1ns/1ps
module dispatch_checker
	import dispatch_pkg::*;
(
	input wire logic       clock,               // system clock
	input wire logic       rst,                 // async reset
	input wire logic       dispatch_strobe,     // handler start
	input wire logic [2:0] dispatch_source,     // started source
	input wire prio_t      active_prio,         // running priority
	input wire logic [7:0] level_mask_set,      // level masks
	input wire logic [7:0] handler_installed,   // handler present
	input wire logic       os_service_busy,     // service running
	input wire logic       interrupts_disabled, // global disable
	input wire logic       oneshot_activate,    // one-shot load
	input wire ms_count_t  oneshot_value,       // one-shot ms
	input wire ms_count_t  system_word_101,     // running duration
	input wire logic       scan_overrun_signal, // scan overrun
	input wire logic       restart_active,      // restart running
	input wire logic       stop_mode            // stop state
);
	// ==============================
	// helpers: inputs as seen at the firing edge
	logic [7:0] mask_q;
	logic [7:0] inst_q;
	ms_count_t  act_q;
	always_ff @(posedge clock) begin
		mask_q <= level_mask_set;
		inst_q <= handler_installed;
	end
	always_ff @(posedge clock) begin
		if (oneshot_activate) act_q <= oneshot_value;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// ==============================
	// assertions
	AST_PREEMPT_LOWER_ONLY: assert property (dispatch_strobe |->
		active_prio < 4'h6 && active_prio <= {1'b0, dispatch_source}) else $error("bad preemption");
	AST_MASK_HONOURED: assert property (dispatch_strobe |-> !mask_q[dispatch_source])
		else $error("masked level dispatched");
	AST_INSTALLED_ONLY: assert property (dispatch_strobe |-> inst_q[dispatch_source])
		else $error("missing handler dispatched");
	AST_SERVICE_BLOCKS: assert property (dispatch_strobe |-> !$past(os_service_busy))
		else $error("dispatch during service");
	AST_DISABLE_BLOCKS: assert property (dispatch_strobe && interrupts_disabled |->
		dispatch_source > 3'h4) else $error("dispatch while disabled");
	AST_WORD_LOAD: assert property (oneshot_activate && oneshot_value != 16'h0001 |->
		##[1:3] system_word_101 == act_q) else $error("duration word not loaded");
	AST_WORD_HOLD: assert property (system_word_101 != 16'h0000 && !oneshot_activate &&
		!$past(oneshot_activate) && !$past(oneshot_activate, 2) |=>
		($stable(system_word_101) || system_word_101 == 16'h0000)) else $error("duration word moved");
	AST_OVERRUN_STOP: assert property (scan_overrun_signal && !handler_installed[7] &&
		!restart_active |-> ##[1:3] stop_mode) else $error("no stop on overrun");
	cover property (dispatch_strobe && active_prio != 4'h0);
	cover property (dispatch_strobe && dispatch_source == 3'h5);
	cover property ($rose(stop_mode));
endmodule : dispatch_checker

bind priority_interrupt_dispatcher dispatch_checker checker_inst (
	.clock(clock), .rst(rst), .dispatch_strobe(dispatch_strobe),
	.dispatch_source(dispatch_source), .active_prio(active_prio),
	.level_mask_set(level_mask_set), .handler_installed(handler_installed),
	.os_service_busy(os_service_busy), .interrupts_disabled(interrupts_disabled),
	.oneshot_activate(oneshot_activate), .oneshot_value(oneshot_value),
	.system_word_101(system_word_101), .scan_overrun_signal(scan_overrun_signal),
	.restart_active(restart_active), .stop_mode(stop_mode)
);

// File: tb/priority_interrupt_dispatcher_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, (e), (g)); end end
module priority_interrupt_dispatcher_tb
	import dispatch_pkg::*;
;
	localparam int LMIN = 4;
	localparam int LMAX = 16;
	localparam int TICK = 8;
	logic clock = 1'b0, rst = 1'b1, io_error = 1'b0, scan_overrun_signal = 1'b0;
	logic scan_timer_restart = 1'b0, oneshot_activate = 1'b0, handler_done = 1'b0;
	logic global_interrupt_disable = 1'b0, global_interrupt_enable = 1'b0;
	logic op_boundary = 1'b0, os_service_busy = 1'b0, restart_active = 1'b0;
	logic [3:0] trig = 4'h0, irq_line;
	logic [7:0] level_mask_set = 8'h00, handler_installed = 8'hFF, pending;
	ms_count_t oneshot_value = 16'h0000, system_word_101;
	logic dispatch_strobe, stop_mode, interrupts_disabled;
	logic [2:0] dispatch_source;
	logic [3:0] collision_code;
	prio_t active_prio;
	int fails = 0, checks_done = 0, lat;

	always #5 clock = ~clock;
	irq_source_model partner (.clock(clock), .trig(trig), .irq_line(irq_line));
	priority_interrupt_dispatcher #(.LAT_MIN_CYC(LMIN), .LAT_MAX_CYC(LMAX), .TICK_CYC(TICK),
		.STACK_DEPTH(9)) dut (.clock, .rst, .irq_line, .io_error, .scan_overrun_signal,
		.scan_timer_restart, .oneshot_activate, .oneshot_value, .global_interrupt_disable,
		.global_interrupt_enable, .level_mask_set, .handler_installed, .op_boundary,
		.os_service_busy, .restart_active, .handler_done, .dispatch_strobe, .dispatch_source,
		.active_prio, .pending, .stop_mode, .system_word_101, .collision_code,
		.interrupts_disabled);

	// ==============================
	// access tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	task automatic fire(input logic [3:0] m);
		trig = m; cyc(1); trig = 4'h0; cyc(1);
	endtask : fire
	task automatic done();
		handler_done = 1'b1; cyc(1); handler_done = 1'b0; cyc(1);
	endtask : done
	task automatic activate(input ms_count_t v);
		oneshot_value = v; oneshot_activate = 1'b1; cyc(1); oneshot_activate = 1'b0; cyc(1);
	endtask : activate
	task automatic glob(input logic en);
		global_interrupt_enable = en; global_interrupt_disable = !en; cyc(1);
		global_interrupt_enable = 1'b0; global_interrupt_disable = 1'b0; cyc(1);
	endtask : glob
	task automatic overrun();
		scan_overrun_signal = 1'b1; cyc(1); scan_overrun_signal = 1'b0; cyc(1);
	endtask : overrun
	// bounded wait; a timeout shows as a missing strobe bit
	task automatic expect_src(input logic [2:0] s);
		lat = 0;
		while (dispatch_strobe !== 1'b1 && lat < 60) begin cyc(1); lat++; end
		`CHK("source", {1'b1, s}, {dispatch_strobe, dispatch_source})
		cyc(1);
	endtask : expect_src
	task automatic expect_none(input int n);
		int seen;
		seen = 0;
		repeat (n) begin cyc(1); if (dispatch_strobe !== 1'b0) seen++; end
		`CHK("no_dispatch", 0, seen)
	endtask : expect_none
	task automatic overrun_stop();
		overrun(); cyc(2);
		`CHK("stop", 1'b1, stop_mode)
		restart_active = 1'b1; cyc(2); restart_active = 1'b0; cyc(3);
		`CHK("run", 1'b0, stop_mode)
	endtask : overrun_stop
	task automatic final_report();
		if (fails == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report

	// ==============================
	// tests
	initial begin
		repeat (6) @(posedge clock);
		#1 rst = 1'b0;
		cyc(2);
		fire(4'hC); expect_src(3'h3);
		`CHK("lat_max", 1'b1, lat >= LMAX && lat <= LMAX + 6)
		cyc(2); `CHK("prio_a", 4'h4, active_prio)
		op_boundary = 1'b1;
		done(); expect_src(3'h2);
		`CHK("lat_min", 1'b1, lat >= LMIN - 1 && lat <= LMIN + 6)
		fire(4'h8); expect_src(3'h3);
		fire(4'h4); fire(4'h8); done(); expect_src(3'h3);
		done(); cyc(2); `CHK("resume_b", 4'h3, active_prio)
		done(); expect_src(3'h2); done();
		glob(1'b0); level_mask_set = 8'h01; fire(4'h3); expect_none(30);
		`CHK("held", 2'b11, pending[1:0])
		glob(1'b1); expect_src(3'h1); done(); expect_none(30);
		level_mask_set = 8'h00; expect_src(3'h0); done();
		handler_installed = 8'hFB; fire(4'h4); expect_none(30);
		`CHK("dropped", 1'b0, pending[2])
		handler_installed = 8'hFF;
		os_service_busy = 1'b1; fire(4'h8); expect_none(30);
		os_service_busy = 1'b0; expect_src(3'h3); done();
		activate(16'h0003); cyc(3); `CHK("word", 16'h0003, system_word_101)
		expect_src(3'h4);
		`CHK("tick", 1'b1, lat + 5 >= 2 * TICK + LMIN && lat + 5 <= 3 * TICK + LMIN + 8)
		`CHK("word_clr", 16'h0000, system_word_101)
		fire(4'h8); expect_none(30); done(); expect_src(3'h3); done();
		activate(16'h0005); cyc(5); activate(16'h0000); cyc(3);
		`CHK("word_stop", 16'h0000, system_word_101)
		expect_none(60);
		glob(1'b0); `CHK("gdis", 1'b1, interrupts_disabled)
		// collision level masked first so its unprocessed code can be seen
		level_mask_set = 8'h20; activate(16'h0001); cyc(20);
		activate(16'h0001); cyc(20);
		`CHK("coll", 4'h1, collision_code)
		level_mask_set = 8'h00; expect_src(3'h5);
		`CHK("coll_done", 4'h0, collision_code)
		done(); overrun(); io_error = 1'b1; expect_src(3'h7); done();
		expect_src(3'h6); done(); io_error = 1'b0;
		glob(1'b1); expect_src(3'h4); done();
		overrun_stop();
		handler_installed = 8'h7F; overrun_stop(); handler_installed = 8'hFF;
		overrun(); expect_src(3'h7); done();
		scan_timer_restart = 1'b1; cyc(1); scan_timer_restart = 1'b0;
		overrun(); expect_src(3'h7); done();
		`CHK("rearmed", 1'b0, stop_mode)
		restart_active = 1'b1; fire(4'h1); expect_none(30);
		restart_active = 1'b0; expect_src(3'h0); done();
		restart_active = 1'b1; glob(1'b1); fire(4'h1); expect_src(3'h0); done();
		restart_active = 1'b0;
		final_report();
	end
	// run needs a few hundred cycles; this bound only trips on a hang
	initial begin
		#100us;
		fails++;
		final_report();
	end
endmodule : priority_interrupt_dispatcher_tb
